// *** rtl/tssc_pkg.sv ***
// Package for the transmit SYNC_N / SYSREF control block.
// Assumes a single 200 MHz link-side clock and a plain register port.
package tssc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] TSSC_CTRL_OFS = 8'h54;
    localparam logic [7:0] TSSC_ERR_OFS = 8'h60;
    localparam logic [7:0] TSSC_MASK_OFS = 8'h64;
    localparam logic [7:0] TSSC_STAT_OFS = 8'h80;

    ////////////////////////////////////////////////////////////////////////////
    // Control register field positions
    localparam int TSSC_CTRL_REINIT_POS = 0;
    localparam int TSSC_CTRL_CONT_POS = 1;
    localparam int TSSC_CTRL_ONESHOT_POS = 2;
    localparam int TSSC_CTRL_SPARE_LSB = 3;
    localparam int TSSC_CTRL_SPARE_MSB = 6;
    localparam int TSSC_CTRL_OFFSET_LSB = 12;
    localparam int TSSC_CTRL_OFFSET_MSB = 19;

    // Error register field positions
    localparam int TSSC_ERR_LMFC_POS = 1;
    localparam int TSSC_ERR_REINIT_POS = 4;

    // Status word field positions
    localparam int TSSC_STAT_SYNCN_POS = 0;
    localparam int TSSC_STAT_SEEN_POS = 1;
    localparam int TSSC_STAT_STATE_LSB = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and write masks
    localparam logic [31:0] TSSC_CTRL_RESET = 32'h0000_0004;
    localparam logic [31:0] TSSC_ERR_RESET = 32'h0000_0000;
    localparam logic [31:0] TSSC_MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] TSSC_CTRL_WMASK = 32'h000F_F07F;
    localparam logic [31:0] TSSC_ERR_WMASK = 32'h0000_0012;

    // Default multiframe shape, F octets times K frames
    localparam int TSSC_F_DEFAULT = 2;
    localparam int TSSC_K_DEFAULT = 32;
    localparam int TSSC_LMFC_DIV = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Link state, one-hot
    typedef enum logic [2:0] {
        TSSC_ST_CGS = 3'b001,
        TSSC_ST_ILAS = 3'b010,
        TSSC_ST_DATA = 3'b100
    } tssc_state_type;

    // Register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } tssc_bus_req_type;

    // Link-facing status
    typedef struct packed {
        logic cgs;
        logic ilas;
        logic data;
        logic k28_5;
    } tssc_link_type;

endpackage : tssc_pkg

// *** rtl/tssc_edge_det.sv ***
// Rising edge detector for a synchronous level.
// Assumes the input is already synchronous to the clock.
`timescale 1ns/1ps
module tssc_edge_det (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic level_in,
    output logic rise_out
);

    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = level_in;
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    assign rise_out = level_in & ~prev_q;

endmodule : tssc_edge_det

// *** rtl/tssc_lmfc_counter.sv ***
// Local multiframe counter with loadable offset and period check.
// Assumes load and period check strobes come from the control logic.
`timescale 1ns/1ps
module tssc_lmfc_counter #(
    parameter int PERIOD = 16,
    parameter int W = 8
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic load_in,
    input wire logic [W-1:0] offset_in,
    input wire logic check_in,
    output logic boundary_out,
    output logic mismatch_out
);

    localparam logic [W-1:0] LAST = W'(PERIOD - 1);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic [W-1:0] load_val;

    // Out-of-range offset falls back to zero
    always_comb begin
        load_val = (offset_in > LAST) ? '0 : offset_in;
        if (load_in) begin
            cnt_d = load_val;
        end else if (cnt_q == LAST) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + W'(1);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign boundary_out = (cnt_q == LAST);
    // Edge arriving where the free-running count would not land means period mismatch
    assign mismatch_out = check_in & (cnt_d != load_val | cnt_q != (load_val == '0 ? LAST
                          : load_val - W'(1)));

endmodule : tssc_lmfc_counter

// *** rtl/tssc_sync_ctrl.sv ***
// Transmit SYNC_N / SYSREF control: LMFC alignment, CGS gate, period check, restart.
// Assumes SYSREF and SYNC_N are synchronous to core_clk_in; plain register port.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module tssc_sync_ctrl #(
    parameter int F = tssc_pkg::TSSC_F_DEFAULT,
    parameter int K = tssc_pkg::TSSC_K_DEFAULT,
    parameter int ILAS_MF = 4
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic sysref_in,
    input wire logic sync_n_in,
    output logic link_cgs_out,
    output logic link_ilas_out,
    output logic link_data_out,
    output logic lmfc_tick_out,
    output logic irq_out
);

    localparam int PERIOD = (F * K) / tssc_pkg::TSSC_LMFC_DIV;

    ////////////////////////////////////////////////////////////////////////////
    // Bus request bundle
    tssc_pkg::tssc_bus_req_type req;
    assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};

    logic wr_ctrl;
    logic wr_err;
    logic wr_mask;
    assign wr_ctrl = req.wr && req.addr == tssc_pkg::TSSC_CTRL_OFS;
    assign wr_err = req.wr && req.addr == tssc_pkg::TSSC_ERR_OFS;
    assign wr_mask = req.wr && req.addr == tssc_pkg::TSSC_MASK_OFS;

    ////////////////////////////////////////////////////////////////////////////
    // SYSREF edge and LMFC
    logic sysref_rise;
    logic boundary;
    logic mismatch;
    logic lmfc_load;
    logic period_check;
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;

    tssc_edge_det u_sysref_edge (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .level_in(sysref_in),
        .rise_out(sysref_rise)
    );

    logic oneshot;
    logic cont;
    assign oneshot = ctrl_q[tssc_pkg::TSSC_CTRL_ONESHOT_POS];
    assign cont = ctrl_q[tssc_pkg::TSSC_CTRL_CONT_POS];

    // Realign on any edge while either mode is armed
    assign lmfc_load = sysref_rise & (oneshot | cont);
    // Check only between two edges seen in continuous mode
    logic armed_q;
    logic armed_d;
    assign period_check = sysref_rise & cont & armed_q;

    tssc_lmfc_counter #(
        .PERIOD(PERIOD),
        .W(8)
    ) u_lmfc (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .load_in(lmfc_load),
        .offset_in(ctrl_q[tssc_pkg::TSSC_CTRL_OFFSET_MSB:tssc_pkg::TSSC_CTRL_OFFSET_LSB]),
        .check_in(period_check),
        .boundary_out(boundary),
        .mismatch_out(mismatch)
    );

    always_comb begin
        armed_d = armed_q;
        if (!cont) begin
            armed_d = 1'b0;
        end else if (sysref_rise) begin
            armed_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= armed_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link state machine
    tssc_pkg::tssc_state_type state_q;
    tssc_pkg::tssc_state_type state_d;
    logic seen_q;
    logic seen_d;
    logic [7:0] ilas_cnt_q;
    logic [7:0] ilas_cnt_d;
    logic reinit_req;
    logic reinit_take;
    logic sync_drop;

    assign reinit_req = ctrl_q[tssc_pkg::TSSC_CTRL_REINIT_POS];
    assign sync_drop = ~sync_n_in & (state_q != tssc_pkg::TSSC_ST_CGS);
    assign reinit_take = reinit_req | sync_drop;

    always_comb begin
        state_d = state_q;
        ilas_cnt_d = ilas_cnt_q;
        seen_d = seen_q | sysref_rise;
        if (reinit_take) begin
            state_d = tssc_pkg::TSSC_ST_CGS;
            ilas_cnt_d = '0;
        end else begin
            unique case (state_q)
                tssc_pkg::TSSC_ST_CGS: begin
                    // Leaving early would give undeterministic latency
                    if (seen_q && !oneshot && boundary && sync_n_in) begin
                        state_d = tssc_pkg::TSSC_ST_ILAS;
                        ilas_cnt_d = '0;
                    end
                end
                tssc_pkg::TSSC_ST_ILAS: begin
                    if (boundary) begin
                        if (ilas_cnt_q == 8'(ILAS_MF - 1)) begin
                            state_d = tssc_pkg::TSSC_ST_DATA;
                        end else begin
                            ilas_cnt_d = ilas_cnt_q + 8'h01;
                        end
                    end
                end
                tssc_pkg::TSSC_ST_DATA: begin
                    state_d = tssc_pkg::TSSC_ST_DATA;
                end
                default: begin
                    state_d = tssc_pkg::TSSC_ST_CGS;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_q <= tssc_pkg::TSSC_ST_CGS;
            seen_q <= 1'b0;
            ilas_cnt_q <= 8'h00;
        end else begin
            state_q <= state_d;
            seen_q <= seen_d;
            ilas_cnt_q <= ilas_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = req.wdata & tssc_pkg::TSSC_CTRL_WMASK;
        end
        // Hardware clears win over a same-cycle write
        if (lmfc_load && oneshot) begin
            ctrl_d[tssc_pkg::TSSC_CTRL_ONESHOT_POS] = 1'b0;
        end
        if (reinit_req) begin
            ctrl_d[tssc_pkg::TSSC_CTRL_REINIT_POS] = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ctrl_q <= tssc_pkg::TSSC_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error status and mask
    logic [31:0] err_q;
    logic [31:0] err_d;
    logic [31:0] mask_q;
    logic [31:0] mask_d;
    logic [31:0] err_set;

    always_comb begin
        err_set = '0;
        err_set[tssc_pkg::TSSC_ERR_LMFC_POS] = mismatch;
        err_set[tssc_pkg::TSSC_ERR_REINIT_POS] = sync_drop;
        err_d = err_q;
        if (wr_err) begin
            err_d = err_q & ~(req.wdata & tssc_pkg::TSSC_ERR_WMASK);
        end
        // Set wins over clear
        err_d = err_d | err_set;
        mask_d = wr_mask ? (req.wdata & tssc_pkg::TSSC_ERR_WMASK) : mask_q;
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            err_q <= tssc_pkg::TSSC_ERR_RESET;
            mask_q <= tssc_pkg::TSSC_MASK_RESET;
        end else begin
            err_q <= err_d;
            mask_q <= mask_d;
        end
    end

    assign irq_out = |(err_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] tx_status_word;

    always_comb begin
        tx_status_word = '0;
        tx_status_word[tssc_pkg::TSSC_STAT_SYNCN_POS] = sync_n_in;
        tx_status_word[tssc_pkg::TSSC_STAT_SEEN_POS] = seen_q;
        tx_status_word[tssc_pkg::TSSC_STAT_STATE_LSB +: 3] = state_q;
        rdata_d = '0;
        if (req.rd) begin
            unique case (req.addr)
                tssc_pkg::TSSC_CTRL_OFS: rdata_d = ctrl_q;
                tssc_pkg::TSSC_ERR_OFS: rdata_d = err_q;
                tssc_pkg::TSSC_MASK_OFS: rdata_d = mask_q;
                tssc_pkg::TSSC_STAT_OFS: rdata_d = tx_status_word;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Link outputs; CGS means K28.5 is sent
    assign link_cgs_out = state_q[0];
    assign link_ilas_out = state_q[1];
    assign link_data_out = state_q[2];
    assign lmfc_tick_out = boundary;

endmodule : tssc_sync_ctrl

// *** verification/tssc_properties.sv ***
// Checker for the SYNC_N / SYSREF control block, watching its top ports.
// Assumes sysref_in idles low and the bench writes only bit 1 of the mask.
`timescale 1ns/1ps
module tssc_properties #(
    parameter int F = 2,
    parameter int K = 32,
    parameter int ILAS_MF = 4
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic sysref_in,
    input wire logic sync_n_in,
    input wire logic link_cgs_out,
    input wire logic link_ilas_out,
    input wire logic link_data_out,
    input wire logic lmfc_tick_out,
    input wire logic irq_out
);
    localparam int P = F * K / 4;
    logic sref_q, seen_q, crise_q, err_q, msk_q, rise, ctl_wr;
    logic [31:0] ctrl_q;
    logic [7:0] mcnt_q, off, nxt;
    assign rise = sysref_in & ~sref_q;
    assign ctl_wr = reg_wr_in && reg_addr_in == tssc_pkg::TSSC_CTRL_OFS;
    assign off = (ctrl_q[19:12] > 8'(P - 1)) ? 8'h00 : ctrl_q[19:12];
    assign nxt = (mcnt_q == 8'(P - 1)) ? 8'h00 : mcnt_q + 8'h01;
    ////////////////////////////////////////////////////////////
    // Reference LMFC and control state, lower bound on errors
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sref_q <= 1'b0;
            seen_q <= 1'b0;
            crise_q <= 1'b0;
            err_q <= 1'b0;
            msk_q <= 1'b0;
            mcnt_q <= 8'h00;
            ctrl_q <= tssc_pkg::TSSC_CTRL_RESET;
        end else begin
            sref_q <= sysref_in;
            seen_q <= seen_q | rise;
            crise_q <= ctrl_q[1] & (crise_q | rise);
            mcnt_q <= (rise && ctrl_q[2:1] != 2'b00) ? off : nxt;
            if (ctl_wr) begin
                ctrl_q <= reg_wdata_in & tssc_pkg::TSSC_CTRL_WMASK;
            end
            // Hardware clear wins over a software write
            if (rise && ctrl_q[2]) begin
                ctrl_q[2] <= 1'b0;
            end
            if (reg_wr_in && reg_addr_in == tssc_pkg::TSSC_MASK_OFS) begin
                msk_q <= reg_wdata_in[1];
            end
            err_q <= (err_q & ~(reg_wr_in && reg_addr_in == tssc_pkg::TSSC_ERR_OFS
                && reg_wdata_in[1])) | (rise && ctrl_q[1] && crise_q && nxt != off);
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    lmfc_align_a: assert property (lmfc_tick_out == (mcnt_q == 8'(P - 1)))
        else $error("LMFC boundary out of place");
    ctrl_read_a: assert property (reg_rd_in && reg_addr_in == tssc_pkg::TSSC_CTRL_OFS
        |=> reg_rdata_out[19:1] == $past(ctrl_q[19:1])) else $error("Control readback wrong");
    cgs_gate_a: assert property (!seen_q |-> link_cgs_out)
        else $error("Left CGS before any SYSREF edge");
    ilas_entry_a: assert property ($rose(link_ilas_out) |->
        $past(lmfc_tick_out && sync_n_in && seen_q && !ctrl_q[2])) else $error("Bad ILAS entry");
    restart_cgs_a: assert property (ctl_wr && reg_wdata_in[0] |-> ##2 link_cgs_out)
        else $error("Restart did not enter CGS");
    no_restart_a: assert property (ctl_wr && !reg_wdata_in[0] && link_data_out && sync_n_in
        |=> link_data_out) else $error("Zero restart bit disturbed the link");
    reinit_clear_a: assert property (ctl_wr && reg_wdata_in[0] ##3
        reg_rd_in && reg_addr_in == tssc_pkg::TSSC_CTRL_OFS |=> !reg_rdata_out[0])
        else $error("Restart bit not cleared");
    irq_set_a: assert property (err_q && msk_q |-> ##[0:1] irq_out)
        else $error("Period error gave no interrupt");
    irq_mask_a: assert property (!msk_q [*2] |-> !irq_out)
        else $error("Interrupt while masked");
    oneshot_hit_c: cover property (rise && ctrl_q[2]);
    data_entry_c: cover property ($rose(link_data_out));
    irq_raise_c: cover property ($rose(irq_out));
endmodule : tssc_properties

// *** verification/tssc_link_model.sv ***
// Far side model: system SYSREF source and converter receiver SYNC_N.
// Assumes one clock; the bench starts, stops and retimes SYSREF.
`timescale 1ns/1ps
module tssc_link_model #(
    parameter int SYNC_DLY = 4
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic run_in,
    input wire logic [7:0] period_in,
    input wire logic cgs_in,
    output logic sysref_out,
    output logic sync_n_out
);
    logic [7:0] ph_q;
    int cgs_q;
    ////////////////////////////////////////////////////////////
    // SYSREF idles low when stopped, so no stray edge appears
    always_ff @(posedge core_clk_in) begin
        if (reset_in || !run_in || ph_q >= period_in - 8'h01) begin
            ph_q <= 8'h00;
        end else begin
            ph_q <= ph_q + 8'h01;
        end
    end
    assign sysref_out = run_in && ph_q < (period_in >> 1);
    // Receiver holds SYNC_N low until it has seen enough K28.5
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            cgs_q <= 0;
        end else if (cgs_in && cgs_q < SYNC_DLY) begin
            cgs_q <= cgs_q + 1;
        end
    end
    assign sync_n_out = cgs_q >= SYNC_DLY;
endmodule : tssc_link_model

// *** verification/tb_tssc_sync_ctrl.sv ***
// Self-checking bench for the SYNC_N / SYSREF control block.
// Assumes tssc_pkg, the link model and the property checker.
`timescale 1ns/1ps
module tb_tssc_sync_ctrl;
    localparam logic [7:0] CTRL = tssc_pkg::TSSC_CTRL_OFS;
    localparam logic [7:0] ERR = tssc_pkg::TSSC_ERR_OFS;
    localparam logic [7:0] MASK = tssc_pkg::TSSC_MASK_OFS;
    localparam logic [7:0] STAT = tssc_pkg::TSSC_STAT_OFS;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic [31:0] reg_rdata_out, ctl;
    logic [31:0] lfsr = 32'h5430FA82;
    logic sysref_in, sync_n_in, cgs, ilas, data, tick, irq_out;
    logic run_q = 1'b0;
    logic [7:0] per_q = 8'h20;
    logic rd_d = 1'b0;
    logic [71:0] note;
    logic [71:0] notes[$];
    int bad_count = 0;
    int n_checks = 0;
    always #2.5 core_clk_in = ~core_clk_in;
    tssc_sync_ctrl DUT (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .sysref_in(sysref_in),
        .sync_n_in(sync_n_in), .link_cgs_out(cgs), .link_ilas_out(ilas),
        .link_data_out(data), .lmfc_tick_out(tick), .irq_out(irq_out));
    tssc_link_model #(.SYNC_DLY(5)) PEER (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .run_in(run_q), .period_in(per_q), .cgs_in(cgs), .sysref_out(sysref_in),
        .sync_n_out(sync_n_in));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // One strobe cycle, then one idle edge so strobes never collide
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        reg_wr_in <= w;
        reg_rd_in <= r;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        @(posedge core_clk_in);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back({a, e, m});
        bus(1'b0, 1'b1, a, 32'h0000_0000);
    endtask : rd
    // Sampled mid-cycle, away from the edge that updates the flags
    task automatic chk_irq(input logic e);
        @(negedge core_clk_in);
        n_checks++;
        if (irq_out !== e) begin
            bad_count++;
            $display("ERROR irq_out exp %b got %b", e, irq_out);
        end
        @(posedge core_clk_in);
    endtask : chk_irq
    task automatic chk_link(input logic [2:0] e);
        @(negedge core_clk_in);
        n_checks++;
        if ({data, ilas, cgs} !== e) begin
            bad_count++;
            $display("ERROR link state exp %b got %b", e, {data, ilas, cgs});
        end
        @(posedge core_clk_in);
    endtask : chk_link
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    always @(posedge core_clk_in) rd_d <= reg_rd_in;
    // Read data stand only in the cycle after the strobe
    always @(negedge core_clk_in) begin
        if (rd_d) begin
            note = notes.pop_front();
            n_checks++;
            if ((reg_rdata_out & note[31:0]) !== note[63:32]) begin
                bad_count++;
                $display("ERROR read %h exp %h got %h", note[71:64], note[63:32],
                    reg_rdata_out & note[31:0]);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge core_clk_in);
        bad_count++;
        results();
    end
    initial begin
        repeat (6) @(posedge core_clk_in);
        reset_in <= 1'b0;
        @(posedge core_clk_in);
        rd(CTRL, 32'h0000_0004, 32'hFFFF_FFFF);
        rd(ERR, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(MASK, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(STAT, 32'h0000_0004, 32'h0000_001E);
        lfsr = lfsr_next(lfsr);
        ctl = 32'h0000_0004 | (32'(lfsr[3:0]) << 3);
        bus(1'b1, 1'b0, CTRL, ctl);
        rd(CTRL, ctl, 32'hFFFF_FFFF);
        repeat (64) @(posedge core_clk_in);
        rd(STAT, 32'h0000_0004, 32'h0000_001C);
        lfsr = lfsr_next(lfsr);
        ctl = ctl | (32'(lfsr[7:4]) << 12);
        bus(1'b1, 1'b0, CTRL, ctl);
        run_q <= 1'b1;
        @(posedge sysref_in);
        repeat (2) @(posedge core_clk_in);
        run_q <= 1'b0;
        @(posedge core_clk_in);
        rd(CTRL, ctl & ~32'h0000_0004, 32'h000F_F07E);
        rd(STAT, 32'h0000_0002, 32'h0000_0002);
        repeat (20) @(posedge core_clk_in);
        rd(STAT, 32'h0000_0000, 32'h0000_0004);
        repeat (80) @(posedge core_clk_in);
        rd(STAT, 32'h0000_0010, 32'h0000_001C);
        chk_link(3'b100);
        // Both modes together would be usual; continuous alone here
        ctl = ctl & 32'h000F_F000;
        bus(1'b1, 1'b0, CTRL, ctl | 32'h0000_0002);
        bus(1'b1, 1'b0, MASK, 32'h0000_0002);
        run_q <= 1'b1;
        repeat (128) @(posedge core_clk_in);
        rd(ERR, 32'h0000_0000, 32'h0000_0002);
        chk_irq(1'b0);
        bus(1'b1, 1'b0, CTRL, ctl);
        run_q <= 1'b0;
        per_q <= 8'h18;
        repeat (8) @(posedge core_clk_in);
        bus(1'b1, 1'b0, CTRL, ctl | 32'h0000_0002);
        run_q <= 1'b1;
        repeat (100) @(posedge core_clk_in);
        run_q <= 1'b0;
        rd(ERR, 32'h0000_0002, 32'h0000_0002);
        chk_irq(1'b1);
        bus(1'b1, 1'b0, MASK, 32'h0000_0000);
        chk_irq(1'b0);
        bus(1'b1, 1'b0, CTRL, ctl);
        bus(1'b1, 1'b0, ERR, 32'h0000_0002);
        rd(ERR, 32'h0000_0000, 32'h0000_0002);
        bus(1'b1, 1'b0, MASK, 32'h0000_0002);
        chk_irq(1'b0);
        rd(STAT, 32'h0000_0011, 32'h0000_001D);
        bus(1'b1, 1'b0, CTRL, ctl);
        rd(STAT, 32'h0000_0010, 32'h0000_001C);
        bus(1'b1, 1'b0, CTRL, ctl | 32'h0000_0005);
        @(posedge core_clk_in);
        rd(CTRL, ctl | 32'h0000_0004, 32'h000F_F07F);
        rd(STAT, 32'h0000_0004, 32'h0000_001C);
        chk_link(3'b001);
        repeat (2) @(posedge core_clk_in);
        results();
    end
endmodule : tb_tssc_sync_ctrl
bind tssc_sync_ctrl tssc_properties #(.F(F), .K(K), .ILAS_MF(ILAS_MF)) u_props (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .sysref_in(sysref_in), .sync_n_in(sync_n_in),
    .link_cgs_out(link_cgs_out), .link_ilas_out(link_ilas_out),
    .link_data_out(link_data_out), .lmfc_tick_out(lmfc_tick_out), .irq_out(irq_out));
